// [rtl/dss_defines.svh]
/*
  Constants of the digital setpoint scaler: register indices, reset values,
  special codes and timing figures. Assumes inclusion by bare name only.
*/
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH
`define DSS_A_MODE    4'h0
`define DSS_A_INC     4'h1
`define DSS_A_BCD_B   4'h2
`define DSS_A_BCD_G   4'h3
`define DSS_A_BIN_B   4'h4
`define DSS_A_BIN_G   4'h5
`define DSS_A_TQ_B    4'h6
`define DSS_A_TQ_G    4'h7
`define DSS_A_TQ_SRC  4'h8
`define DSS_A_REF     4'h9
`define DSS_A_ACC     4'hA
`define DSS_A_DEC     4'hB
`define DSS_A_SPEED   4'hC
`define DSS_A_RAMP    4'hD
`define DSS_A_TQ_OUT  4'hE
`define DSS_DIRECT    16'h270F
`define DSS_RST_MODE  16'h270F
`define DSS_RST_INC   2'h1
`define DSS_RST_SGAIN 16'h0258
`define DSS_RST_TGAIN 16'h0096
`define DSS_RST_REF   16'h1770
`define DSS_RST_TIME  16'h0032
`define DSS_TQ_MAX    16'h0190
`define DSS_TQ_SRC_DIG 8'h04
`define DSS_MS_PER_UNIT 100
`define DSS_CLK_KHZ     10000
`define DSS_CYC_PER_UNIT (`DSS_MS_PER_UNIT * `DSS_CLK_KHZ)
`endif

// [rtl/dss_pkg.sv]
/*
  Types of the digital setpoint scaler. Assumes nothing of its users.
*/
package dss_pkg;
  // Active speed source, highest priority first.
  typedef enum logic [2:0] {
    DSS_SRC_JOG   = 3'b000,
    DSS_SRC_STOP  = 3'b001,
    DSS_SRC_MULTI = 3'b010,
    DSS_SRC_PID   = 3'b011,
    DSS_SRC_CURR  = 3'b100,
    DSS_SRC_PULSE = 3'b101,
    DSS_SRC_DIG   = 3'b110,
    DSS_SRC_VOLT  = 3'b111
  } dss_src_t;
  // Speed source select levels from the terminal block.
  typedef struct packed {
    logic inching_select;
    logic second_function_select;
    logic low_speed_select;
    logic mid_speed_select;
    logic high_speed_select;
    logic process_loop_select;
    logic current_input_select;
  } dss_sel_t;
  // Meaning of one input mode code.
  typedef struct packed {
    logic valid;
    logic bcd;
    logic wide;
    logic comp;
    logic torque;
  } dss_mode_t;
endpackage

// [rtl/dss_scaler.sv]
/*
  Digital setpoint scaler: turns a parallel 12/16-bit BCD or binary word into
  a speed or torque setpoint, ramps the speed and picks the speed source.
  Assumes pins are asynchronous, and analog compensation and pulse train
  enable come from logic on clk.
*/
`timescale 1ns/10ps
`include "dss_defines.svh"
module dss_scaler #(
  parameter logic [39:0] CYC_PER_UNIT = 40'(`DSS_CYC_PER_UNIT)
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [3:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [31:0]           rdata,
  input  wire logic [15:0]           setpoint_in_lines,
  input  wire dss_pkg::dss_sel_t     sel_in,
  input  wire logic                  pulse_train_en,
  input  wire logic signed [27:0]    analog_comp,
  output logic      [26:0]           speed_setpoint,
  output logic      [26:0]           ramp_speed,
  output logic signed [10:0]         torque_setpoint,
  output logic                       torque_cmd_active,
  output dss_pkg::dss_src_t          speed_source,
  output logic                       analog_v_enable,
  output logic      [2:0]            torque_src_kind
);

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // Classifies an input mode code.
  function automatic dss_pkg::dss_mode_t mode_info(input logic [15:0] m);
    dss_pkg::dss_mode_t r;
    r = '0;
    case (m)
      16'h0000: r = 5'b11000;
      16'h0001: r = 5'b10000;
      16'h0002: r = 5'b11010;
      16'h0003: r = 5'b10010;
      16'h0004: r = 5'b10001;
      16'h000A: r = 5'b11100;
      16'h000B: r = 5'b10100;
      16'h000C: r = 5'b11110;
      16'h000D: r = 5'b10110;
      16'h000E: r = 5'b10101;
      default:  r = '0;
    endcase
    return r;
  endfunction

  // Divides by the full-scale count of the word format in use.
  function automatic logic signed [47:0] div_fs(input logic signed [47:0] n,
                                                input logic [1:0] f);
    logic signed [47:0] r;
    r = '0;
    case (f)
      2'b00:   r = n / 48'sd999;
      2'b01:   r = n / 48'sd9999;
      2'b10:   r = n / 48'sd4095;
      default: r = n / 48'sd65535;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // Parameter registers
  // ------------------------------------------------------------
  logic [15:0] mode_reg;      // Input mode select.
  logic [1:0]  inc_reg;       // Unit increment select.
  logic [15:0] bcd_bias_reg;  // BCD speed bias, 0.1 Hz.
  logic [15:0] bcd_gain_reg;  // BCD speed gain, 0.1 Hz or direct code.
  logic [15:0] bin_bias_reg;  // Binary speed bias, 0.1 Hz.
  logic [15:0] bin_gain_reg;  // Binary speed gain, 0.1 Hz or direct code.
  logic [15:0] tq_bias_reg;   // Torque bias, percent.
  logic [15:0] tq_gain_reg;   // Torque gain, percent or direct code.
  logic [7:0]  tq_src_reg;    // Torque source select.
  logic [15:0] ref_reg;       // Ramp reference frequency, 0.01 Hz.
  logic [15:0] acc_t_reg;     // Acceleration time, 0.1 s.
  logic [15:0] dec_t_reg;     // Deceleration time, 0.1 s.

  // Software writes; percentages above 400 are clipped on write.
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg     <= `DSS_RST_MODE;
      inc_reg      <= `DSS_RST_INC;
      bcd_bias_reg <= '0;
      bcd_gain_reg <= `DSS_RST_SGAIN;
      bin_bias_reg <= '0;
      bin_gain_reg <= `DSS_RST_SGAIN;
      tq_bias_reg  <= '0;
      tq_gain_reg  <= `DSS_RST_TGAIN;
      tq_src_reg   <= '0;
      ref_reg      <= `DSS_RST_REF;
      acc_t_reg    <= `DSS_RST_TIME;
      dec_t_reg    <= `DSS_RST_TIME;
    end else if (wr) begin
      case (addr)
        `DSS_A_MODE:   mode_reg     <= wdata[15:0];
        `DSS_A_INC:    inc_reg      <= wdata[1:0];
        `DSS_A_BCD_B:  bcd_bias_reg <= wdata[15:0];
        `DSS_A_BCD_G:  bcd_gain_reg <= wdata[15:0];
        `DSS_A_BIN_B:  bin_bias_reg <= wdata[15:0];
        `DSS_A_BIN_G:  bin_gain_reg <= wdata[15:0];
        `DSS_A_TQ_B:   tq_bias_reg  <= (wdata[15:0] > `DSS_TQ_MAX) ? `DSS_TQ_MAX : wdata[15:0];
        `DSS_A_TQ_G:   tq_gain_reg  <= (wdata[15:0] > `DSS_TQ_MAX && wdata[15:0] != `DSS_DIRECT)
                                       ? `DSS_TQ_MAX : wdata[15:0];
        `DSS_A_TQ_SRC: tq_src_reg   <= wdata[7:0];
        `DSS_A_REF:    ref_reg      <= wdata[15:0];
        `DSS_A_ACC:    acc_t_reg    <= wdata[15:0];
        `DSS_A_DEC:    dec_t_reg    <= wdata[15:0];
        default:       ;
      endcase
    end
  end

  // Read data appear in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        `DSS_A_MODE:   rdata <= {16'h0000, mode_reg};
        `DSS_A_INC:    rdata <= {30'h0000_0000, inc_reg};
        `DSS_A_BCD_B:  rdata <= {16'h0000, bcd_bias_reg};
        `DSS_A_BCD_G:  rdata <= {16'h0000, bcd_gain_reg};
        `DSS_A_BIN_B:  rdata <= {16'h0000, bin_bias_reg};
        `DSS_A_BIN_G:  rdata <= {16'h0000, bin_gain_reg};
        `DSS_A_TQ_B:   rdata <= {16'h0000, tq_bias_reg};
        `DSS_A_TQ_G:   rdata <= {16'h0000, tq_gain_reg};
        `DSS_A_TQ_SRC: rdata <= {24'h00_0000, tq_src_reg};
        `DSS_A_REF:    rdata <= {16'h0000, ref_reg};
        `DSS_A_ACC:    rdata <= {16'h0000, acc_t_reg};
        `DSS_A_DEC:    rdata <= {16'h0000, dec_t_reg};
        `DSS_A_SPEED:  rdata <= {5'h00, speed_setpoint};
        `DSS_A_RAMP:   rdata <= {5'h00, ramp_speed};
        `DSS_A_TQ_OUT: rdata <= {{21{torque_setpoint[10]}}, torque_setpoint};
        default:       rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [15:0]       in_s1;  // First stage, read only by in_s2.
  logic [15:0]       in_s2;  // Synchronised input word.
  dss_pkg::dss_sel_t sel_s1; // First stage, read only by sel_s2.
  dss_pkg::dss_sel_t sel_s2; // Synchronised select levels.

  // Two flops on every pin before any logic looks at it.
  always_ff @(posedge clk) begin
    if (reset) begin
      in_s1  <= '0;
      in_s2  <= '0;
      sel_s1 <= '0;
      sel_s2 <= '0;
    end else begin
      in_s1  <= setpoint_in_lines;
      in_s2  <= in_s1;
      sel_s1 <= sel_in;
      sel_s2 <= sel_s1;
    end
  end

  // ------------------------------------------------------------
  // Decode stage
  // ------------------------------------------------------------
  dss_pkg::dss_mode_t info;    // Current mode meaning.
  logic [15:0]        word_m;  // Word with unused lines masked.
  logic [15:0]        dec_reg; // Decoded value.
  logic [15:0]        raw_reg; // Masked raw word for torque.
  logic               bad_reg; // Some BCD digit is out of range.
  logic [1:0]         fs_reg;  // Full-scale selector for scaling.
  logic               prev_bin_reg; // Previous cycle was binary mode.

  assign info   = mode_info(mode_reg);
  assign word_m = info.wide ? in_s2 : {4'h0, in_s2[11:0]};

  // Decodes BCD or binary and flags bad BCD digits.
  always_ff @(posedge clk) begin
    if (reset) begin
      dec_reg <= '0;
      raw_reg <= '0;
      bad_reg <= 1'b0;
      fs_reg  <= '0;
    end else begin
      raw_reg <= word_m;
      fs_reg  <= {~info.bcd, info.wide};
      // Digits are checked in every mode, so a switch to BCD sees a bad word at once.
      bad_reg <= (word_m[3:0] > 4'h9) || (word_m[7:4] > 4'h9) ||
                 (word_m[11:8] > 4'h9) || (word_m[15:12] > 4'h9);
      if (info.bcd) begin
        dec_reg <= 16'(word_m[3:0] + 10 * word_m[7:4] + 100 * word_m[11:8] + 1000 * word_m[15:12]);
      end else begin
        dec_reg <= word_m;
      end
    end
  end

  // ------------------------------------------------------------
  // Speed setpoint stage
  // ------------------------------------------------------------
  logic [15:0]        s_bias;  // Bias for the active coding.
  logic [15:0]        s_gain;  // Gain for the active coding.
  logic signed [47:0] s_dir;   // Direct-value result, 0.01 Hz.
  logic signed [47:0] s_scl;   // Bias/gain result, 0.01 Hz.
  logic signed [47:0] s_next;  // Candidate setpoint.
  logic               bad_now; // Bad BCD digit in a BCD mode.

  assign s_bias  = info.bcd ? bcd_bias_reg : bin_bias_reg;
  assign s_gain  = info.bcd ? bcd_gain_reg : bin_gain_reg;
  assign bad_now = info.bcd && bad_reg;

  // Builds the candidate speed in 0.01 Hz from the decoded value.
  always_comb begin
    case (inc_reg)
      2'h0:    s_dir = 48'(dec_reg) * 48'sd1000;
      2'h1:    s_dir = 48'(dec_reg) * 48'sd100;
      2'h2:    s_dir = 48'(dec_reg) * 48'sd10;
      default: s_dir = 48'(dec_reg);
    endcase
    s_scl = 48'(s_bias) * 48'sd10 +
            div_fs((48'(s_gain) - 48'(s_bias)) * 48'sd10 * 48'(dec_reg), fs_reg);
    // Increment only matters with the direct code.
    s_next = (s_gain == `DSS_DIRECT) ? s_dir : s_scl;
    if (info.comp) begin
      s_next = s_next + 48'(analog_comp);
    end
    if (s_next < 0) begin
      s_next = '0;
    end else if (s_next > 48'sd134217727) begin
      s_next = 48'sd134217727;
    end
  end

  // Updates the held speed one cycle after decode.
  always_ff @(posedge clk) begin
    if (reset) begin
      speed_setpoint <= '0;
      prev_bin_reg   <= 1'b0;
    end else begin
      prev_bin_reg <= info.valid && !info.bcd;
      if (!info.valid || info.torque) begin
        speed_setpoint <= '0;
      end else if (bad_now && prev_bin_reg) begin
        speed_setpoint <= '0;
      end else if (!bad_now) begin
        speed_setpoint <= s_next[26:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Torque setpoint stage
  // ------------------------------------------------------------
  logic [14:0]        t_mag;  // Torque magnitude.
  logic               t_neg;  // Torque sign.
  logic signed [47:0] t_val;  // Unsigned torque value, percent.
  logic               t_take; // Digital input drives torque.
  logic signed [47:0] t_span; // Gain minus bias, kept signed so a falling line works.

  assign t_span = $signed(48'(tq_gain_reg)) - $signed(48'(tq_bias_reg));

  assign t_mag  = info.wide ? raw_reg[14:0] : {4'h0, raw_reg[10:0]};
  assign t_neg  = info.wide ? raw_reg[15] : raw_reg[11];
  assign t_take = info.torque && (tq_src_reg == `DSS_TQ_SRC_DIG);

  // Maps magnitude to percent, direct or interpolated.
  always_comb begin
    if (tq_gain_reg == `DSS_DIRECT) begin
      t_val = (t_mag > 15'(`DSS_TQ_MAX)) ? 48'(`DSS_TQ_MAX) : 48'(t_mag);
    end else if (info.wide) begin
      t_val = $signed(48'(tq_bias_reg)) + t_span * $signed(48'(t_mag)) / 48'sd32767;
    end else begin
      t_val = $signed(48'(tq_bias_reg)) + t_span * $signed(48'(t_mag)) / 48'sd2047;
    end
  end

  // Holds the signed torque command and its source class.
  always_ff @(posedge clk) begin
    if (reset) begin
      torque_setpoint   <= '0;
      torque_cmd_active <= 1'b0;
      torque_src_kind   <= '0;
    end else begin
      torque_cmd_active <= t_take;
      torque_setpoint   <= !t_take ? 11'sd0 : t_neg ? -11'(t_val) : 11'(t_val);
      case (tq_src_reg)
        8'h00:   torque_src_kind <= 3'h1; // Analog input.
        8'h01:   torque_src_kind <= 3'h2; // Parameter value.
        8'h03:   torque_src_kind <= 3'h3; // Field network.
        8'h06:   torque_src_kind <= 3'h3; // Field network.
        8'h04:   torque_src_kind <= 3'h4; // Digital input.
        default: torque_src_kind <= 3'h0; // Other or unused.
      endcase
    end
  end

  // ------------------------------------------------------------
  // Speed source selection
  // ------------------------------------------------------------
  logic dig_en; // Digital input feeds speed.
  assign dig_en = info.valid && !info.torque;

  // Fixed priority; the voltage input is shut off by the digital input.
  always_ff @(posedge clk) begin
    if (reset) begin
      speed_source    <= dss_pkg::DSS_SRC_VOLT;
      analog_v_enable <= 1'b0;
    end else begin
      analog_v_enable <= !dig_en;
      if (sel_s2.inching_select) begin
        speed_source <= dss_pkg::DSS_SRC_JOG;
      end else if (sel_s2.second_function_select && sel_s2.low_speed_select) begin
        speed_source <= dss_pkg::DSS_SRC_STOP;
      end else if (sel_s2.high_speed_select || sel_s2.mid_speed_select || sel_s2.low_speed_select) begin
        speed_source <= dss_pkg::DSS_SRC_MULTI;
      end else if (sel_s2.process_loop_select) begin
        speed_source <= dss_pkg::DSS_SRC_PID;
      end else if (sel_s2.current_input_select) begin
        speed_source <= dss_pkg::DSS_SRC_CURR;
      end else if (pulse_train_en) begin
        speed_source <= dss_pkg::DSS_SRC_PULSE;
      end else if (dig_en) begin
        speed_source <= dss_pkg::DSS_SRC_DIG;
      end else begin
        speed_source <= dss_pkg::DSS_SRC_VOLT;
      end
    end
  end

  // ------------------------------------------------------------
  // Speed ramp
  // ------------------------------------------------------------
  logic [39:0] r_acc;  // Fractional step accumulator.
  logic [39:0] r_tcyc; // Ramp time in clock cycles.
  logic        r_up;   // Ramp must rise.

  assign r_up   = ramp_speed < speed_setpoint;
  assign r_tcyc = 40'(r_up ? acc_t_reg : dec_t_reg) * CYC_PER_UNIT;

  // Steps by one count each time the reference share of a cycle adds up.
  always_ff @(posedge clk) begin
    if (reset) begin
      ramp_speed <= '0;
      r_acc      <= '0;
    end else if (ramp_speed == speed_setpoint) begin
      r_acc <= '0;
    end else if (r_tcyc == '0) begin
      ramp_speed <= speed_setpoint;
    end else if (r_acc + 40'(ref_reg) >= r_tcyc) begin
      r_acc      <= r_acc + 40'(ref_reg) - r_tcyc;
      ramp_speed <= r_up ? ramp_speed + 27'h000_0001 : ramp_speed - 27'h000_0001;
    end else begin
      r_acc <= r_acc + 40'(ref_reg);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_reset_defaults: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> (inc_reg == `DSS_RST_INC && speed_setpoint == '0 && tq_gain_reg == `DSS_RST_TGAIN))
    else $error("Defaults not loaded by reset.");
  chk_bcd_hold_prev: assert property (@(posedge clk) disable iff (reset)
    (info.valid && !info.torque && bad_now && !prev_bin_reg && $stable(mode_reg)) |=> $stable(speed_setpoint))
    else $error("Bad BCD word changed the setpoint.");
  chk_switch_zero: assert property (@(posedge clk) disable iff (reset)
    (info.valid && bad_now && prev_bin_reg) |=> (speed_setpoint == '0))
    else $error("Setpoint not zero after switch to BCD.");
  chk_torque_gate: assert property (@(posedge clk) disable iff (reset)
    torque_cmd_active |-> ($past(tq_src_reg) == `DSS_TQ_SRC_DIG && $past(info.torque)))
    else $error("Torque taken without digital source.");
  chk_torque_clamp: assert property (@(posedge clk) disable iff (reset)
    $past(tq_gain_reg == `DSS_DIRECT) |-> (torque_setpoint <= 11'sd400 && torque_setpoint >= -11'sd400))
    else $error("Direct torque exceeds 400 percent.");
  chk_volt_disable: assert property (@(posedge clk) disable iff (reset)
    (speed_source == dss_pkg::DSS_SRC_DIG) |-> !analog_v_enable)
    else $error("Voltage input live with digital input.");
  chk_jog_first: assert property (@(posedge clk) disable iff (reset)
    sel_s2.inching_select |=> (speed_source == dss_pkg::DSS_SRC_JOG))
    else $error("Inching did not take priority.");
  chk_ramp_step: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && $past(r_tcyc) != '0 && $past(ramp_speed) != $past(speed_setpoint)) |->
    (ramp_speed - $past(ramp_speed) <= 27'h000_0001 || $past(ramp_speed) - ramp_speed <= 27'h000_0001))
    else $error("Ramp stepped by more than one count.");
  chk_torque_sign: assert property (@(posedge clk) disable iff (reset)
    (t_take && t_neg && t_val > 0) |=> (torque_setpoint < 0))
    else $error("Negative sign not applied to torque.");
endmodule

// [sim/dss_ctrl_model.sv]
/*
  Controller model: drives the parallel setpoint lines of the scaler.
  Assumes the bench raises load just after a rising clock edge.
*/
`timescale 1ns/10ps
module dss_ctrl_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        load,
  input  wire logic [15:0] word,
  output logic      [15:0] lines
);
  // The lines clear with reset and move only on a rising clock edge with load high, like latched pins.
  always_ff @(posedge clk) begin
    if (reset) begin
      lines <= 16'h0000;
    end else if (load) begin
      lines <= word;
    end
  end
endmodule

// [sim/dss_scaler_bench.sv]
/*
  Self-checking bench of the setpoint scaler.
  Assumes the controller model and a shortened ramp count.
*/
`timescale 1ns/10ps
`include "dss_defines.svh"
module dss_scaler_bench;
  logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, load = 1'b0, pte = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [15:0] word = 16'h0000, lines;
  logic [26:0] spd, rmp;
  logic signed [27:0] comp = 28'h000_0000;
  logic signed [10:0] tq;
  logic tqa, ave;
  logic [2:0] tkind;
  dss_pkg::dss_sel_t sel = '0;
  dss_pkg::dss_src_t src;
  int error_cnt = 0, checks_done = 0, v, m, k;
  int modes[4] = '{1, 3, 11, 13};
  int tsrc[5] = '{0, 1, 3, 4, 6};
  int tknd[5] = '{1, 2, 3, 4, 3};
  logic [6:0] sels[6] = '{7'h7F, 7'h3F, 7'h1F, 7'h03, 7'h01, 7'h00};
  // A free-running clock of 100 ns.
  always #50 clk = ~clk;
  dss_ctrl_model ctl (.clk(clk), .reset(reset), .load(load), .word(word), .lines(lines));
  dss_scaler #(.CYC_PER_UNIT(40'd10)) dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .setpoint_in_lines(lines), .sel_in(sel), .pulse_train_en(pte),
    .analog_comp(comp), .speed_setpoint(spd), .ramp_speed(rmp), .torque_setpoint(tq),
    .torque_cmd_active(tqa), .speed_source(src), .analog_v_enable(ave), .torque_src_kind(tkind));
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h want %0h", $time, g, e);
    end
  endtask
  // One-cycle register write.
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read; data is looked at in the following cycle only.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Lets the synchroniser and decode pipeline settle.
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // Hands a word to the controller model, then settles.
  task automatic put(input logic [15:0] w);
    @(posedge clk);
    load <= 1'b1;
    word <= w;
    @(posedge clk);
    load <= 1'b0;
    settle;
  endtask
  // Direct speed: value times increment, plus compensation where enabled.
  function automatic int f_dir(input int w, input int md, input int inc);
    int mul[4] = '{1000, 100, 10, 1};
    int val;
    val = (md < 10) ? (w & 'hFFF) : w;
    return val * mul[inc] + ((md == 3 || md == 13) ? int'(comp) : 0);
  endfunction
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog that cuts a hang short.
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
  // Main sequence.
  initial begin
    v = $urandom(19650);
    comp <= 28'($urandom & 'h3FF);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd_chk(`DSS_A_MODE, 32'h0000_270F);
    rd_chk(`DSS_A_INC, 32'h0000_0001);
    rd_chk(`DSS_A_TQ_G, 32'h0000_0096);
    rd_chk(`DSS_A_TQ_B, 32'h0000_0000);
    rd_chk(4'hF, 32'h0000_0000);
    wr_reg(`DSS_A_TQ_G, 32'h0000_01F4);
    rd_chk(`DSS_A_TQ_G, 32'h0000_0190);
    chk(src, dss_pkg::DSS_SRC_VOLT);
    chk(ave, 1'b1);
    // Direct speed over every increment; bias must not count.
    wr_reg(`DSS_A_BIN_B, 32'h0000_0064);
    wr_reg(`DSS_A_BIN_G, `DSS_DIRECT);
    for (m = 0; m < 4; m++) begin
      for (k = 0; k < 4; k++) begin
        wr_reg(`DSS_A_MODE, modes[m]);
        wr_reg(`DSS_A_INC, k);
        v = $urandom & 'hFFFF;
        put(v);
        chk(spd, f_dir(v, modes[m], k));
      end
    end
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    #1 chk(spd, 0);
    rd_chk(`DSS_A_BIN_G, 32'h0000_0258);
    // Scaled speed ignores the increment.
    wr_reg(`DSS_A_BIN_B, 32'h0000_0064);
    wr_reg(`DSS_A_MODE, 32'h0000_000B);
    for (k = 0; k < 4; k++) begin
      wr_reg(`DSS_A_INC, k);
      v = $urandom & 'hFFFF;
      put(v);
      chk(spd, 1000 + 5000 * v / 65535);
    end
    // BCD words: valid, invalid held, and the switch from binary.
    wr_reg(`DSS_A_BCD_G, `DSS_DIRECT);
    wr_reg(`DSS_A_BIN_G, `DSS_DIRECT);
    wr_reg(`DSS_A_INC, 32'h0000_0001);
    wr_reg(`DSS_A_MODE, 32'h0000_0000);
    put(16'h0111);
    chk(spd, 11100);
    put(16'h01A1);
    chk(spd, 11100);
    wr_reg(`DSS_A_MODE, 32'h0000_0001);
    wr_reg(`DSS_A_MODE, 32'h0000_0000);
    settle;
    chk(spd, 0);
    wr_reg(`DSS_A_MODE, 32'h0000_0002);
    put(16'h0123);
    chk(spd, 12300 + comp);
    // Torque in direct form at 16 bits and scaled form at 16 and 12 bits.
    wr_reg(`DSS_A_MODE, 32'h0000_000E);
    wr_reg(`DSS_A_TQ_SRC, 32'h0000_0004);
    wr_reg(`DSS_A_TQ_G, `DSS_DIRECT);
    put(16'h81F4);
    chk(tq, -400);
    chk(tqa, 1'b1);
    put(16'h0064);
    chk(tq, 100);
    wr_reg(`DSS_A_TQ_G, 32'h0000_0096);
    put(16'hFFFF);
    chk(tq, -150);
    v = $urandom & 'h7FFF;
    put(v);
    chk(tq, 150 * v / 32767);
    wr_reg(`DSS_A_MODE, 32'h0000_0004);
    put(16'hF7FF);
    chk(tq, 150);
    for (k = 0; k < 5; k++) begin
      wr_reg(`DSS_A_TQ_SRC, tsrc[k]);
      settle;
      chk(tkind, tknd[k]);
      chk(tqa, k == 3);
    end
    // Speed source priority, removing the highest source each step.
    wr_reg(`DSS_A_MODE, 32'h0000_0001);
    @(posedge clk);
    pte <= 1'b1;
    for (k = 0; k < 6; k++) begin
      @(posedge clk);
      sel <= dss_pkg::dss_sel_t'(sels[k]);
      settle;
      chk(src, k);
    end
    @(posedge clk);
    pte <= 1'b0;
    settle;
    chk(src, dss_pkg::DSS_SRC_DIG);
    chk(ave, 1'b0);
    // Ramp: jump with zero time, then one count per cycle to 50.
    wr_reg(`DSS_A_ACC, 32'h0000_0000);
    wr_reg(`DSS_A_DEC, 32'h0000_0000);
    wr_reg(`DSS_A_INC, 32'h0000_0003);
    put(16'h0000);
    chk(rmp, 0);
    wr_reg(`DSS_A_REF, 32'h0000_000A);
    wr_reg(`DSS_A_ACC, 32'h0000_0001);
    put(16'h0032);
    chk(rmp > 0 && rmp < 50, 1'b1);
    for (k = 0; k < 200 && rmp !== 27'd50; k++) begin
      @(posedge clk);
      #1;
    end
    chk(rmp, 50);
    chk(k > 30 && k < 60, 1'b1);
    tally_and_finish;
  end
endmodule
